// *** core_clock_ratio_consts.vh ***
`ifndef CORE_CLOCK_RATIO_CONSTS_VH
`define CORE_CLOCK_RATIO_CONSTS_VH

// Register byte offsets
`define REG_CTRL_OFS        12'h000
`define REG_STATUS_OFS      12'h004
`define REG_EFFECTIVE_OFS   12'h008
`define REG_CTRL_RESET      32'h00000000

// Control register fields
`define CTRL_HALVING_LSB    0
`define CTRL_HALVING_MSB    1

// Status register fields
`define STS_MULT_LSB        0
`define STS_MULT_MSB        5
`define STS_KIND_LSB        6
`define STS_KIND_MSB        7
`define STS_ACK_DELAY_BIT   8
`define STS_RESERVED_BIT    9
`define STS_TEST_BIT        10
`define STS_VALID_BIT       11
`define STS_CODE_LSB        16
`define STS_CODE_MSB        21

// Frequency halving modes
`define HALVING_OFF         2'h0
`define HALVING_HALF        2'h1
`define HALVING_QUARTER     2'h2

// Decoded clock kinds, held in table entry bits [7:6]
`define KIND_RESERVED       2'h0
`define KIND_PLL            2'h1
`define KIND_BYPASS         2'h2
`define KIND_OFF            2'h3

// Special ratio codes, written as printed (leftmost digit is bit 5 here)
`define CODE_BYPASS         6'h0C
`define CODE_PLL_OFF        6'h3C

// Multipliers are held doubled so half steps stay integral; below 5x needs late ack
`define ACK_DELAY_LIMIT_X2  6'h0A

// AHB transfer types and response
`define HTRANS_IDLE         2'h0
`define HTRANS_NONSEQ       2'h2
`define HRESP_OKAY          1'h0

`endif

// *** ratio_table_rom.v ***
`timescale 1ns/1ps
`default_nettype none

`include "core_clock_ratio_consts.vh"

// Ratio code lookup; entry is {kind[1:0], multiplier_x2[5:0]}, read data registered
module ratio_table_rom (
	input  wire       i_mclk,
	input  wire       i_rst,
	input  wire [5:0] i_addr,
	output reg  [7:0] o_data
);
	reg [7:0] entry;

	always @* begin
		case (i_addr)
			6'h10:   entry = {`KIND_PLL, 6'h04};
			6'h20:   entry = {`KIND_PLL, 6'h06};
			6'h28:   entry = {`KIND_PLL, 6'h08};
			6'h2C:   entry = {`KIND_PLL, 6'h0A};
			6'h24:   entry = {`KIND_PLL, 6'h0B};
			6'h34:   entry = {`KIND_PLL, 6'h0C};
			6'h14:   entry = {`KIND_PLL, 6'h0D};
			6'h08:   entry = {`KIND_PLL, 6'h0E};
			6'h04:   entry = {`KIND_PLL, 6'h0F};
			6'h30:   entry = {`KIND_PLL, 6'h10};
			6'h18:   entry = {`KIND_PLL, 6'h11};
			6'h1E:   entry = {`KIND_PLL, 6'h12};
			6'h1C:   entry = {`KIND_PLL, 6'h13};
			6'h2A:   entry = {`KIND_PLL, 6'h14};
			6'h22:   entry = {`KIND_PLL, 6'h15};
			6'h26:   entry = {`KIND_PLL, 6'h16};
			6'h00:   entry = {`KIND_PLL, 6'h17};
			6'h2E:   entry = {`KIND_PLL, 6'h18};
			6'h3E:   entry = {`KIND_PLL, 6'h19};
			6'h16:   entry = {`KIND_PLL, 6'h1A};
			6'h38:   entry = {`KIND_PLL, 6'h1B};
			6'h32:   entry = {`KIND_PLL, 6'h1C};
			6'h06:   entry = {`KIND_PLL, 6'h1E};
			6'h36:   entry = {`KIND_PLL, 6'h20};
			6'h02:   entry = {`KIND_PLL, 6'h22};
			6'h0A:   entry = {`KIND_PLL, 6'h24};
			6'h0E:   entry = {`KIND_PLL, 6'h28};
			6'h12:   entry = {`KIND_PLL, 6'h2A};
			6'h1A:   entry = {`KIND_PLL, 6'h30};
			6'h3A:   entry = {`KIND_PLL, 6'h38};
			`CODE_BYPASS:  entry = {`KIND_BYPASS, 6'h02};
			`CODE_PLL_OFF: entry = {`KIND_OFF, 6'h00};
			default: entry = {`KIND_RESERVED, 6'h00};
		endcase
	end

	always @(posedge i_mclk) begin
		if (i_rst) begin
			o_data <= 8'h00;
		end else begin
			o_data <= entry;
		end
	end
endmodule

`default_nettype wire

// *** core_clock_ratio_decode.v ***
`timescale 1ns/1ps
`default_nettype none

`include "core_clock_ratio_consts.vh"

// How it works
// RL1 - The ratio code decodes to a bus-to-core multiplier of 2x to 28x, with VCO at 1x of core.
// RL2 - Only listed codes may be applied; any other code is reserved, reported and clocks nothing.
// RL3 - Code 001100 turns the PLL off and runs the core straight from the system bus clock.
// RL4 - In bypass the far side drives the bus qualifier at half the bus clock, offset in phase.
// RL5 - In bypass the processor bus runs at half the system bus clock and the core at full rate.
// RL6 - Bypass is meant only for factory test and emulator use, never normal operation.
// RL7 - Code 111100 keeps the PLL off and stops all core clocking whatever the bus clock does.
// RL8 - The decoded multiplier holds only while frequency halving is off.
// RL9 - Below 5x the bus controller must delay address acknowledge by one or two bus cycles; o_ack_delay_req is raised in PLL mode only, not in bypass.
// RL10 - The test bit of the ratio code must be held low by the configuration source.
// RL11 - With frequency halving on, the decoded multiplier is divided by two or by four.
// RL12 - The ratio code is held stable from before reset release and stays static.
module core_clock_ratio_decode (
	input  wire        i_mclk,
	input  wire        i_rst,
	input  wire [5:0]  i_ratio_sel,
	input  wire        i_bypass_bus_qualifier,
	input  wire        i_hsel,
	input  wire [31:0] i_haddr,
	input  wire [1:0]  i_htrans,
	input  wire        i_hwrite,
	input  wire [2:0]  i_hsize,
	input  wire [31:0] i_hwdata,
	input  wire        i_hready,
	output wire        o_hreadyout,
	output wire        o_hresp,
	output reg  [31:0] o_hrdata,
	output reg         o_pll_enable,
	output reg         o_core_clk_en,
	output reg         o_bus_clk_en,
	output reg  [5:0]  o_bus_to_core_x2,
	output reg  [7:0]  o_effective_x8,
	output reg         o_ack_delay_req,
	output reg         o_reserved_code
);
	// Pin synchronisers: three stages, a code change counts once stages two and three agree
	reg [5:0] sel_s1;
	reg [5:0] sel_s2;
	reg [5:0] sel_s3;
	reg [5:0] sel_stable;
	reg       qual_s1;
	reg       qual_s2;
	reg       qual_s3;
	reg       qual_stable;
	reg       qual_prev;
	reg       sel_valid;
	reg [2:0] sel_fill;

	always @(posedge i_mclk) begin
		if (i_rst) begin
			sel_s1      <= 6'h00;
			sel_s2      <= 6'h00;
			sel_s3      <= 6'h00;
			sel_stable  <= 6'h00;
			sel_valid   <= 1'b0;
			sel_fill    <= 3'h0;
			qual_s1     <= 1'b0;
			qual_s2     <= 1'b0;
			qual_s3     <= 1'b0;
			qual_stable <= 1'b0;
			qual_prev   <= 1'b0;
		end else begin
			sel_s1    <= i_ratio_sel;
			sel_s2    <= sel_s1;
			sel_s3    <= sel_s2;
			sel_fill  <= {sel_fill[1:0], 1'b1};
			// Code is a static strap, so one settled sample is enough (see RL12);
			// stage three must hold the pin itself, not the reset zeros
			if (sel_fill[2] && sel_s2 == sel_s3) begin
				sel_stable <= sel_s3;
				sel_valid  <= 1'b1;
			end
			qual_s1   <= i_bypass_bus_qualifier;
			qual_s2   <= qual_s1;
			qual_s3   <= qual_s2;
			// The qualifier flips every cycle, so stages two and three never agree on it
			qual_stable <= qual_s3;
			qual_prev <= qual_stable;
		end
	end

	// Table lookup
	wire [7:0] table_entry;

	ratio_table_rom u_table (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_addr (sel_stable),
		.o_data (table_entry)
	);

	reg table_valid;

	always @(posedge i_mclk) begin
		if (i_rst) begin
			table_valid <= 1'b0;
		end else begin
			table_valid <= sel_valid;
		end
	end

	wire [1:0] kind      = table_entry[7:6];
	wire [5:0] mult_x2   = table_entry[5:0];
	wire       test_bit  = sel_stable[0];

	// Operating mode, one-hot; it leaves waiting only once the table answer is valid
	localparam [4:0] MODE_WAIT     = 5'h01;
	localparam [4:0] MODE_PLL      = 5'h02;
	localparam [4:0] MODE_BYPASS   = 5'h04;
	localparam [4:0] MODE_OFF      = 5'h08;
	localparam [4:0] MODE_RESERVED = 5'h10;

	reg [4:0] mode;
	reg [4:0] next_mode;

	// A code that moves later is followed, as straps are expected static (see RL12)
	always @* begin
		next_mode = MODE_WAIT;
		if (table_valid) begin
			case (kind)
				`KIND_PLL:    next_mode = MODE_PLL;
				`KIND_BYPASS: next_mode = MODE_BYPASS;
				`KIND_OFF:    next_mode = MODE_OFF;
				default:      next_mode = MODE_RESERVED;
			endcase
		end
	end

	always @(posedge i_mclk) begin
		if (i_rst) begin
			mode <= MODE_WAIT;
		end else begin
			mode <= next_mode;
		end
	end

	// Kind field as software sees it, taken from the mode in force
	function [1:0] mode_kind;
		input [4:0] m;
		begin
			case (m)
				MODE_PLL:    mode_kind = `KIND_PLL;
				MODE_BYPASS: mode_kind = `KIND_BYPASS;
				MODE_OFF:    mode_kind = `KIND_OFF;
				default:     mode_kind = `KIND_RESERVED;
			endcase
		end
	endfunction

	// Control register, written over the bus
	reg [1:0] halving_mode;

	// Effective multiplier in eighths; quarter of 10.5x must stay exact
	reg [7:0] next_effective_x8;

	always @* begin
		next_effective_x8 = {mult_x2, 2'b00};
		case (halving_mode)
			`HALVING_HALF: begin
				next_effective_x8 = {1'b0, mult_x2, 1'b0}; // see RL11
			end
			`HALVING_QUARTER: begin
				next_effective_x8 = {2'b00, mult_x2}; // see RL11
			end
			default: begin
				next_effective_x8 = {mult_x2, 2'b00}; // see RL8
			end
		endcase
	end

	// Clock control outputs follow the mode being entered, so both change together
	always @(posedge i_mclk) begin
		if (i_rst) begin
			o_pll_enable     <= 1'b0;
			o_core_clk_en    <= 1'b0;
			o_bus_clk_en     <= 1'b0;
			o_bus_to_core_x2 <= 6'h00;
			o_effective_x8   <= 8'h00;
			o_ack_delay_req  <= 1'b0;
			o_reserved_code  <= 1'b0;
		end else begin
			o_reserved_code  <= (next_mode == MODE_RESERVED); // see RL2
			case (next_mode)
				MODE_PLL: begin
					o_pll_enable     <= 1'b1; // see RL1
					o_core_clk_en    <= 1'b1;
					o_bus_clk_en     <= 1'b1;
					o_bus_to_core_x2 <= mult_x2; // see RL1
					o_effective_x8   <= next_effective_x8; // see RL8
					o_ack_delay_req  <= (mult_x2 < `ACK_DELAY_LIMIT_X2); // see RL9
				end
				MODE_BYPASS: begin
					o_pll_enable     <= 1'b0; // see RL3
					o_core_clk_en    <= 1'b1; // see RL3
					// Bus steps once per qualifier rise, half the system clock (see RL5)
					o_bus_clk_en     <= qual_stable & ~qual_prev; // see RL4
					o_bus_to_core_x2 <= mult_x2;
					o_effective_x8   <= 8'h00;
					o_ack_delay_req  <= 1'b0;
				end
				MODE_OFF: begin
					o_pll_enable     <= 1'b0; // see RL7
					o_core_clk_en    <= 1'b0; // see RL7
					o_bus_clk_en     <= 1'b0;
					o_bus_to_core_x2 <= mult_x2;
					o_effective_x8   <= 8'h00;
					o_ack_delay_req  <= 1'b0;
				end
				MODE_RESERVED: begin
					// Reserved code: fail safe, nothing clocks
					o_pll_enable     <= 1'b0;
					o_core_clk_en    <= 1'b0;
					o_bus_clk_en     <= 1'b0;
					o_bus_to_core_x2 <= mult_x2;
					o_effective_x8   <= 8'h00;
					o_ack_delay_req  <= 1'b0;
				end
				default: begin
					o_pll_enable     <= 1'b0;
					o_core_clk_en    <= 1'b0;
					o_bus_clk_en     <= 1'b0;
					o_bus_to_core_x2 <= 6'h00;
					o_effective_x8   <= 8'h00;
					o_ack_delay_req  <= 1'b0;
				end
			endcase
		end
	end

	// AHB-Lite slave, zero wait states
	reg        dph_write;
	reg [11:0] dph_addr;

	localparam [31:0] CTRL_RESET = `REG_CTRL_RESET;

	wire addr_phase = i_hsel & i_hready & (i_htrans == `HTRANS_NONSEQ);

	// A read right behind a control write must see the value being written
	wire [1:0] ctrl_now = (dph_write && dph_addr == `REG_CTRL_OFS) ?
		i_hwdata[`CTRL_HALVING_MSB:`CTRL_HALVING_LSB] : halving_mode;

	assign o_hreadyout = 1'b1;
	assign o_hresp     = `HRESP_OKAY;

	reg [31:0] status_word;

	always @* begin
		status_word = 32'h00000000;
		status_word[`STS_MULT_MSB:`STS_MULT_LSB] = o_bus_to_core_x2;
		status_word[`STS_KIND_MSB:`STS_KIND_LSB] = mode_kind(mode);
		status_word[`STS_ACK_DELAY_BIT]          = o_ack_delay_req;
		status_word[`STS_RESERVED_BIT]           = o_reserved_code;
		status_word[`STS_TEST_BIT]               = test_bit; // see RL10
		status_word[`STS_VALID_BIT]              = (mode != MODE_WAIT);
		status_word[`STS_CODE_MSB:`STS_CODE_LSB] = sel_stable;
	end

	// Register read decode; unmapped words read zero
	function [31:0] read_mux;
		input [11:0] addr;
		input [1:0]  halving;
		input [31:0] status;
		input [7:0]  effective;
		begin
			case (addr)
				`REG_CTRL_OFS:      read_mux = {30'h00000000, halving};
				`REG_STATUS_OFS:    read_mux = status;
				`REG_EFFECTIVE_OFS: read_mux = {24'h000000, effective};
				default:            read_mux = 32'h00000000;
			endcase
		end
	endfunction

	always @(posedge i_mclk) begin
		if (i_rst) begin
			dph_write    <= 1'b0;
			dph_addr     <= 12'h000;
			o_hrdata     <= 32'h00000000;
			halving_mode <= CTRL_RESET[1:0];
		end else begin
			if (i_hready) begin
				dph_write <= addr_phase & i_hwrite;
				dph_addr  <= {i_haddr[11:2], 2'b00};
			end
			if (addr_phase & ~i_hwrite) begin
				o_hrdata <= read_mux({i_haddr[11:2], 2'b00}, ctrl_now,
					status_word, o_effective_x8);
			end
			if (dph_write && dph_addr == `REG_CTRL_OFS) begin
				halving_mode <= i_hwdata[`CTRL_HALVING_MSB:`CTRL_HALVING_LSB];
			end
		end
	end

	// Only word transfers are used; the size is not checked
	wire unused_ok = &{1'b0, i_hsize, i_haddr[31:12], i_haddr[1:0]};
endmodule

`default_nettype wire

// *** core_clock_ratio_decode_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module core_clock_ratio_decode_checker (
	input wire logic        i_mclk,
	input wire logic        i_rst,
	input wire logic        i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0]  i_htrans,
	input wire logic        i_hwrite,
	input wire logic [31:0] i_hwdata,
	input wire logic        i_hready,
	input wire logic        o_pll_enable,
	input wire logic        o_core_clk_en,
	input wire logic        o_bus_clk_en,
	input wire logic [5:0]  o_bus_to_core_x2,
	input wire logic [7:0]  o_effective_x8,
	input wire logic        o_ack_delay_req
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// Control write taken, then its data phase while the PLL runs
	sequence s_ctrl_wr;
		i_hsel && i_hready && i_htrans == 2'h2 && i_hwrite && i_haddr[11:0] == 12'h000
		##1 o_pll_enable;
	endsequence
	property p_pll_range;
		o_pll_enable |-> o_bus_to_core_x2 >= 6'h04 && o_bus_to_core_x2 <= 6'h38;
	endproperty
	a_pll_range: assert property (p_pll_range) else $error("multiplier range");
	property p_pll_clocks;
		o_pll_enable |-> o_core_clk_en && o_bus_clk_en;
	endproperty
	a_pll_clocks: assert property (p_pll_clocks) else $error("pll clocks");
	property p_bypass_x2;
		o_core_clk_en && !o_pll_enable |-> o_bus_to_core_x2 == 6'h02;
	endproperty
	a_bypass_x2: assert property (p_bypass_x2) else $error("bypass ratio");
	property p_bypass_pulse;
		o_core_clk_en && !o_pll_enable && o_bus_clk_en |=> !o_bus_clk_en;
	endproperty
	a_bypass_pulse: assert property (p_bypass_pulse) else $error("bypass bus rate");
	property p_off;
		!o_core_clk_en |-> !o_bus_clk_en && !o_pll_enable && o_effective_x8 == 8'h00;
	endproperty
	a_off: assert property (p_off) else $error("clock while off");
	property p_eff_off;
		s_ctrl_wr ##0 i_hwdata[1:0] == 2'h0 |-> ##2 o_effective_x8 == {o_bus_to_core_x2, 2'b00};
	endproperty
	a_eff_off: assert property (p_eff_off) else $error("unhalved value");
	property p_eff_half;
		s_ctrl_wr ##0 i_hwdata[1:0] == 2'h1 |-> ##2
			o_effective_x8 == {1'b0, o_bus_to_core_x2, 1'b0};
	endproperty
	a_eff_half: assert property (p_eff_half) else $error("halved value");
	property p_ack_delay;
		o_ack_delay_req == (o_pll_enable && o_bus_to_core_x2 < 6'h0A);
	endproperty
	a_ack_delay: assert property (p_ack_delay) else $error("late ack flag");
endmodule
bind core_clock_ratio_decode core_clock_ratio_decode_checker i_checker (.i_mclk, .i_rst,
	.i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_pll_enable,
	.o_core_clk_en, .o_bus_clk_en, .o_bus_to_core_x2, .o_effective_x8, .o_ack_delay_req);
`default_nettype wire

// *** core_clock_straps_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module core_clock_straps_model (
	input  wire logic       i_mclk,
	input  wire logic [5:0] i_code,
	input  wire logic       i_qual_run,
	output logic      [5:0] o_ratio_sel,
	output logic            o_bypass_bus_qualifier
);
	// Straps are wired, so the code only moves while reset is held
	assign o_ratio_sel = i_code;
	// Falling-edge toggle gives half rate, half a period clear of the rising edge
	always @(negedge i_mclk) begin
		o_bypass_bus_qualifier <= i_qual_run ? ~o_bypass_bus_qualifier : 1'b0;
	end
endmodule
`default_nettype wire

// *** test_core_clock_ratio_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_core_clock_ratio_decode;
	localparam [255:0] TBL = 256'h1900381B200C1C10180A1408160B1506121330111A0D2A042802240E1E0F2217;
	logic        i_mclk = 1'b0;
	logic        i_rst = 1'b1;
	logic [5:0]  code = 6'h00;
	logic        run = 1'b0;
	logic [5:0]  i_ratio_sel;
	logic        i_bypass_bus_qualifier;
	logic        i_hsel = 1'b0;
	logic [31:0] i_haddr = 32'h0;
	logic [1:0]  i_htrans = 2'h0;
	logic        i_hwrite = 1'b0;
	logic [31:0] i_hwdata = 32'h0;
	logic        o_hreadyout, o_hresp, o_pll_enable, o_core_clk_en, o_bus_clk_en;
	logic        o_ack_delay_req, o_reserved_code, ak;
	logic [31:0] o_hrdata, rd;
	logic [5:0]  o_bus_to_core_x2, ex;
	logic [7:0]  o_effective_x8;
	logic [1:0]  kind, h;
	integer      failures = 0, comparisons = 0, cycles = 0, seed = 11456, n;
	always #5 i_mclk = ~i_mclk;
	core_clock_straps_model i_core_clock_straps_model (.i_mclk, .i_code(code), .i_qual_run(run),
		.o_ratio_sel(i_ratio_sel), .o_bypass_bus_qualifier(i_bypass_bus_qualifier));
	core_clock_ratio_decode i_core_clock_ratio_decode (.i_mclk, .i_rst, .i_ratio_sel,
		.i_bypass_bus_qualifier, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize(3'h2),
		.i_hwdata, .i_hready(o_hreadyout), .o_hreadyout, .o_hresp, .o_hrdata, .o_pll_enable,
		.o_core_clk_en, .o_bus_clk_en, .o_bus_to_core_x2, .o_effective_x8, .o_ack_delay_req,
		.o_reserved_code);
	function automatic logic [7:0] eff_x8(input logic [5:0] m, input logic [1:0] k, hv);
		if (k != 2'h1) return 8'h00;
		if (hv == 2'h1) return {1'b0, m, 1'b0};
		if (hv == 2'h2) return {2'b00, m};
		return {m, 2'b00};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_ready;
		@(posedge i_mclk);
		while (o_hreadyout !== 1'b1) @(posedge i_mclk);
	endtask
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		i_hsel <= 1'b1;
		i_htrans <= 2'h2;
		i_hwrite <= w;
		i_haddr <= a;
		wait_ready();
		i_hsel <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= wd;
		wait_ready();
		rd = o_hrdata;
	endtask
	task automatic print_verdict;
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end
	initial begin
		// Every code, reserved and test-bit ones included, each from a fresh reset
		for (int c = 0; c < 64; c++) begin
			code <= c[5:0];
			run <= (c == 12 || c == 60);
			i_rst <= 1'b1;
			repeat (6) @(posedge i_mclk);
			i_rst <= 1'b0;
			ex = c[0] ? 6'h00 : 6'(TBL[c[5:1]*8 +: 8]);
			kind = (ex >= 6'h04) ? 2'h1 : (c == 12) ? 2'h2 : (c == 60) ? 2'h3 : 2'h0;
			ak = kind == 2'h1 && ex < 6'h0A;
			repeat (8) @(posedge i_mclk);
			n = 0;
			repeat (20) begin
				@(posedge i_mclk);
				n = n + o_bus_clk_en;
			end
			chk(n, (kind == 2'h1) ? 20 : (kind == 2'h2) ? 10 : 0);
			chk(o_bus_to_core_x2, ex);
			chk({o_pll_enable, o_core_clk_en}, {kind == 2'h1, kind[0] ^ kind[1]});
			chk(o_reserved_code, kind == 2'h0);
			chk(o_ack_delay_req, ak);
			chk(o_effective_x8, eff_x8(ex, kind, 2'h0));
			h = 2'($random(seed));
			ahb(1'b1, 32'h0, {30'h0, h});
			ahb(1'b0, 32'h0, 32'h0);
			chk(rd, {30'h0, h});
			chk(o_effective_x8, eff_x8(ex, kind, h));
			ahb(1'b0, 32'h8, 32'h0);
			chk(rd, {24'h0, eff_x8(ex, kind, h)});
			ahb(1'b0, 32'h4, 32'h0);
			chk(rd, {10'h0, c[5:0], 4'h0, 1'b1, c[0], kind == 2'h0, ak, kind, ex});
			ahb(1'b0, {20'h0, 8'($random(seed)), 4'hC}, 32'h0);
			chk(rd, 32'h0);
			chk(o_hresp, 32'h0);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
